// ### inc/cce_map.vh
// Register map, field positions, opcodes and reset values of the instruction execution block.
// Assumes a 32-bit AXI4-Lite bus with one aligned word per register.
`ifndef CCE_MAP_VH
`define CCE_MAP_VH

`define CCE_OFF_CMD 32'h00000000
`define CCE_OFF_ACC 32'h00000004
`define CCE_OFF_LATCH 32'h00000008
`define CCE_OFF_PC 32'h0000000c
`define CCE_OFF_STATUS 32'h00000010
`define CCE_OFF_FADDR 32'h00000014
`define CCE_OFF_FDATA 32'h00000018
`define CCE_OFF_STACK 32'h0000001c
`define CCE_OFF_DOG 32'h00000020

`define CCE_IDX_CMD 4'h0
`define CCE_IDX_ACC 4'h1
`define CCE_IDX_LATCH 4'h2
`define CCE_IDX_PC 4'h3
`define CCE_IDX_STATUS 4'h4
`define CCE_IDX_FADDR 4'h5
`define CCE_IDX_FDATA 4'h6
`define CCE_IDX_STACK 4'h7
`define CCE_IDX_DOG 4'h8
`define CCE_IDX_NONE 4'hf

`define CCE_CMD_OP_LSB 0
`define CCE_CMD_OP_MSB 3
`define CCE_CMD_ADDR_LSB 8
`define CCE_CMD_ADDR_MSB 14
`define CCE_CMD_DEST_BIT 16

`define CCE_OP_NOP 4'h0
`define CCE_OP_ACC_CALL 4'h1
`define CCE_OP_FILE_CLEAR 4'h2
`define CCE_OP_ACC_CLEAR 4'h3
`define CCE_OP_DOG_RESTART 4'h4
`define CCE_OP_FILE_INVERT 4'h5
`define CCE_OP_FILE_DEC 4'h6

`define CCE_ST_ZERO_BIT 0
`define CCE_ST_SLEEP_BIT 1
`define CCE_ST_EXPIRY_BIT 2
`define CCE_ST_BUSY_BIT 8
`define CCE_ST_SP_LSB 16
`define CCE_ST_SP_MSB 19

`define CCE_RESP_OKAY 2'b00
`define CCE_RESP_SLVERR 2'b10
`define CCE_RESET_PC 15'h0000
`define CCE_STACK_DEPTH 16
`define CCE_FILE_DEPTH 128

`endif

// ### design/cce_core.v
// Execution unit for the call-through-accumulator, clear, watchdog restart,
// complement and decrement instructions, with its accumulator, file registers,
// program counter, return stack, status flags and watchdog counters.
// Assumes an AXI4-Lite master on the same clock; software issues instructions
// by writing the command register and observes results through the other registers.
`timescale 1ns/1ps
`default_nettype none
`include "cce_map.vh"

// Notes on behaviour
// - Indirect call pushes program counter plus one onto the return stack first.
// - Call loads counter low byte from accumulator, upper seven bits from upper latch.
// - Indirect call takes two cycles and leaves every status flag alone.
// - Clear file register writes zero to the addressed register and sets zero flag.
// - Clear accumulator writes zero to the accumulator and sets zero flag.
// - Watchdog restart zeroes the watchdog count and its prescaler.
// - Watchdog restart sets expiry and sleep-entry flags to one, nothing else.
// - Complement inverts the register, result to accumulator or register, updates zero.
// - Decrement subtracts one, result to accumulator or register, updates zero.
module cce_core (
   input wire clk,              // 50 MHz clock.
   input wire reset_n,          // Synchronous reset, active low.
   input wire [31:0] awaddr,    // Write address.
   input wire awvalid,          // Write address valid.
   output reg awready,          // Write address ready.
   input wire [31:0] wdata,     // Write data.
   input wire [3:0] wstrb,      // Write byte strobes.
   input wire wvalid,           // Write data valid.
   output reg wready,           // Write data ready.
   output reg [1:0] bresp,      // Write response code.
   output reg bvalid,           // Write response valid.
   input wire bready,           // Write response ready.
   input wire [31:0] araddr,    // Read address.
   input wire arvalid,          // Read address valid.
   output reg arready,          // Read address ready.
   output reg [31:0] rdata,     // Read data.
   output reg [1:0] rresp,      // Read response code.
   output reg rvalid,           // Read data valid.
   input wire rready            // Read data ready.
);

   localparam ST_IDLE = 2'd0;
   localparam ST_RUN = 2'd1;
   localparam ST_CALL1 = 2'd2;
   localparam ST_CALL2 = 2'd3;

   reg [7:0] fileMem [0:`CCE_FILE_DEPTH-1];
   reg [14:0] stackMem [0:`CCE_STACK_DEPTH-1];
   reg [3:0] stackPtr;
   reg [7:0] acc;
   reg [6:0] upperLatch;
   reg [14:0] progCounter;
   reg zeroFlag;
   reg sleepFlag;
   reg expiryFlag;
   reg [7:0] dogCount;
   reg [7:0] dogPrescale;
   reg [6:0] fileAddr;
   reg [31:0] cmdWord;
   reg [1:0] state;
   reg [31:0] awAddrHeld;
   reg awHeld;
   reg [31:0] wDataHeld;
   reg [3:0] wStrbHeld;
   reg wHeld;
   integer i;

   wire [3:0] cmdOp = cmdWord[`CCE_CMD_OP_MSB:`CCE_CMD_OP_LSB];
   wire [6:0] cmdAddr = cmdWord[`CCE_CMD_ADDR_MSB:`CCE_CMD_ADDR_LSB];
   wire cmdDest = cmdWord[`CCE_CMD_DEST_BIT];
   wire [7:0] operand = fileMem[cmdAddr];
   wire [7:0] compResult = ~operand;
   wire [7:0] decResult = operand - 8'h01;
   wire wrFire = awHeld & wHeld & ~bvalid;
   wire [3:0] wrIdx = regIndex(awAddrHeld);
   wire [31:0] wrOld = readValue(wrIdx);
   wire [31:0] wrVal = mergeBytes(wrOld, wDataHeld, wStrbHeld);
   wire [3:0] rdIdx = regIndex(araddr);
   wire [14:0] stackTop = stackMem[stackPtr - 4'h1];

   // Address decode shared by the read and write paths.
   function [3:0] regIndex;
      input [31:0] addr;
      begin
         case (addr)
            `CCE_OFF_CMD: regIndex = `CCE_IDX_CMD;
            `CCE_OFF_ACC: regIndex = `CCE_IDX_ACC;
            `CCE_OFF_LATCH: regIndex = `CCE_IDX_LATCH;
            `CCE_OFF_PC: regIndex = `CCE_IDX_PC;
            `CCE_OFF_STATUS: regIndex = `CCE_IDX_STATUS;
            `CCE_OFF_FADDR: regIndex = `CCE_IDX_FADDR;
            `CCE_OFF_FDATA: regIndex = `CCE_IDX_FDATA;
            `CCE_OFF_STACK: regIndex = `CCE_IDX_STACK;
            `CCE_OFF_DOG: regIndex = `CCE_IDX_DOG;
            default: regIndex = `CCE_IDX_NONE;
         endcase
      end
   endfunction

   // Byte-lane merge so partial writes keep the untouched lanes.
   function [31:0] mergeBytes;
      input [31:0] oldVal;
      input [31:0] newVal;
      input [3:0] strb;
      integer b;
      begin
         mergeBytes = oldVal;
         for (b = 0; b < 4; b = b + 1) begin
            if (strb[b]) mergeBytes[b*8 +: 8] = newVal[b*8 +: 8];
         end
      end
   endfunction

   // Current contents of a register; narrow fields sit low, upper bits read zero.
   function [31:0] readValue;
      input [3:0] idx;
      begin
         readValue = 32'h00000000;
         case (idx)
            `CCE_IDX_CMD: readValue = cmdWord;
            `CCE_IDX_ACC: readValue[7:0] = acc;
            `CCE_IDX_LATCH: readValue[6:0] = upperLatch;
            `CCE_IDX_PC: readValue[14:0] = progCounter;
            `CCE_IDX_STATUS: begin
               readValue[`CCE_ST_ZERO_BIT] = zeroFlag;
               readValue[`CCE_ST_SLEEP_BIT] = sleepFlag;
               readValue[`CCE_ST_EXPIRY_BIT] = expiryFlag;
               readValue[`CCE_ST_BUSY_BIT] = (state != ST_IDLE);
               readValue[`CCE_ST_SP_MSB:`CCE_ST_SP_LSB] = stackPtr;
            end
            `CCE_IDX_FADDR: readValue[6:0] = fileAddr;
            `CCE_IDX_FDATA: readValue[7:0] = fileMem[fileAddr];
            `CCE_IDX_STACK: readValue[14:0] = stackTop;
            `CCE_IDX_DOG: readValue[15:0] = {dogPrescale, dogCount};
            default: readValue = 32'h00000000;
         endcase
      end
   endfunction

   // Write channels are captured independently, so address and data may come in either order.
   always @(posedge clk) begin
      if (!reset_n) begin
         awready <= 1'b0;
         wready <= 1'b0;
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddrHeld <= 32'h00000000;
         wDataHeld <= 32'h00000000;
         wStrbHeld <= 4'h0;
         bvalid <= 1'b0;
         bresp <= `CCE_RESP_OKAY;
      end else begin
         awready <= ~awHeld & ~(awvalid & awready) & ~(bvalid & ~bready);
         wready <= ~wHeld & ~(wvalid & wready) & ~(bvalid & ~bready);
         if (awvalid & awready) begin
            awHeld <= 1'b1;
            awAddrHeld <= awaddr;
         end
         if (wvalid & wready) begin
            wHeld <= 1'b1;
            wDataHeld <= wdata;
            wStrbHeld <= wstrb;
         end
         if (wrFire) begin
            bvalid <= 1'b1;
            bresp <= (wrIdx == `CCE_IDX_NONE) ? `CCE_RESP_SLVERR : `CCE_RESP_OKAY;
            awHeld <= 1'b0;
            wHeld <= 1'b0;
         end else if (bvalid & bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // Read channel: one read outstanding, answered the cycle after the address is taken.
   always @(posedge clk) begin
      if (!reset_n) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= `CCE_RESP_OKAY;
      end else if (arvalid & arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= readValue(rdIdx);
         rresp <= (rdIdx == `CCE_IDX_NONE) ? `CCE_RESP_SLVERR : `CCE_RESP_OKAY;
      end else if (!rvalid | rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end

   // Architectural state. Execution is placed after the bus writes so that an
   // instruction result wins over a software store landing in the same cycle.
   always @(posedge clk) begin
      if (!reset_n) begin
         for (i = 0; i < `CCE_FILE_DEPTH; i = i + 1) begin
            fileMem[i] <= 8'h00;
         end
         for (i = 0; i < `CCE_STACK_DEPTH; i = i + 1) begin
            stackMem[i] <= 15'h0000;
         end
         stackPtr <= 4'h0;
         acc <= 8'h00;
         upperLatch <= 7'h00;
         progCounter <= `CCE_RESET_PC;
         zeroFlag <= 1'b0;
         sleepFlag <= 1'b1;
         expiryFlag <= 1'b1;
         dogCount <= 8'h00;
         dogPrescale <= 8'h00;
         fileAddr <= 7'h00;
         cmdWord <= 32'h00000000;
         state <= ST_IDLE;
      end else begin
         // The watchdog runs freely; a full wrap of both stages marks a timeout.
         dogPrescale <= dogPrescale + 8'h01;
         if (dogPrescale == 8'hff) begin
            dogCount <= dogCount + 8'h01;
            if (dogCount == 8'hff) begin
               expiryFlag <= 1'b0;
            end
         end
         if (wrFire) begin
            case (wrIdx)
               `CCE_IDX_CMD: begin
                  // A command written while busy is dropped; poll the busy bit first.
                  if (state == ST_IDLE) begin
                     cmdWord <= wrVal;
                     state <= (wrVal[3:0] == `CCE_OP_ACC_CALL) ? ST_CALL1 : ST_RUN;
                  end
               end
               `CCE_IDX_ACC: acc <= wrVal[7:0];
               `CCE_IDX_LATCH: upperLatch <= wrVal[6:0];
               `CCE_IDX_PC: begin
                  if (state == ST_IDLE) begin
                     progCounter <= wrVal[14:0];
                  end
               end
               `CCE_IDX_FADDR: fileAddr <= wrVal[6:0];
               `CCE_IDX_FDATA: fileMem[fileAddr] <= wrVal[7:0];
               default: ;
            endcase
         end
         case (state)
            ST_IDLE: ;
            ST_RUN: begin
               state <= ST_IDLE;
               progCounter <= progCounter + 15'h0001;
               case (cmdOp)
                  `CCE_OP_FILE_CLEAR: begin
                     fileMem[cmdAddr] <= 8'h00;
                     zeroFlag <= 1'b1;
                  end
                  `CCE_OP_ACC_CLEAR: begin
                     acc <= 8'h00;
                     zeroFlag <= 1'b1;
                  end
                  `CCE_OP_DOG_RESTART: begin
                     // Written after the free-running update, so a restart beats a timeout.
                     dogCount <= 8'h00;
                     dogPrescale <= 8'h00;
                     expiryFlag <= 1'b1;
                     sleepFlag <= 1'b1;
                  end
                  `CCE_OP_FILE_INVERT: begin
                     // Destination bit low steers the result into the accumulator.
                     if (cmdDest) fileMem[cmdAddr] <= compResult;
                     else acc <= compResult;
                     zeroFlag <= (compResult == 8'h00);
                  end
                  `CCE_OP_FILE_DEC: begin
                     if (cmdDest) fileMem[cmdAddr] <= decResult;
                     else acc <= decResult;
                     zeroFlag <= (decResult == 8'h00);
                  end
                  default: ;
               endcase
            end
            ST_CALL1: begin
               // The stack wraps after sixteen pushes, overwriting the oldest entry.
               stackMem[stackPtr] <= progCounter + 15'h0001;
               stackPtr <= stackPtr + 4'h1;
               state <= ST_CALL2;
            end
            ST_CALL2: begin
               progCounter <= {upperLatch, acc};
               state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

endmodule
`default_nettype wire

// ### tb/cce_core_asserts.sv
// Bus handshake checker for the instruction execution block.
// Assumes one clock and the synchronous active-low reset of cce_core.
`timescale 1ns/1ps
`default_nettype none
module cce_core_asserts (
   input wire logic clk, // Core clock.
   input wire logic reset_n, // Reset, active low.
   input wire logic awvalid, // Write address valid.
   input wire logic awready, // Write address ready.
   input wire logic wvalid, // Write data valid.
   input wire logic wready, // Write data ready.
   input wire logic bvalid, // Write response valid.
   input wire logic bready, // Write response ready.
   input wire logic [1:0] bresp, // Write response code.
   input wire logic [31:0] araddr, // Read address.
   input wire logic arvalid, // Read address valid.
   input wire logic arready, // Read address ready.
   input wire logic rvalid, // Read data valid.
   input wire logic rready, // Read data ready.
   input wire logic [31:0] rdata, // Read data.
   input wire logic [1:0] rresp // Read response code.
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // A write is answered two edges after both halves are taken, a read one edge after;
   // both answers hold until the master takes them.
   write_answer_a: assert property (awvalid && awready && wvalid && wready |=> ##1 bvalid)
      else $error("write not answered");
   read_answer_a: assert property (arvalid && arready |=> rvalid)
      else $error("read not answered");
   bvalid_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped");
   rvalid_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped");
   // Only one transfer of each kind may be open, so readys stay low meanwhile.
   write_closed_a: assert property (bvalid |-> !awready && !wready)
      else $error("write taken while answering");
   read_closed_a: assert property (rvalid |-> !arready)
      else $error("read taken while answering");
   ready_return_a: assert property (bvalid && bready |=> awready && wready)
      else $error("write channel not reopened");
   unmapped_read_a: assert property (arvalid && arready && araddr > 32'h23 |=> rresp == 2'b10)
      else $error("unmapped read not refused");
endmodule
bind cce_core cce_core_asserts chk (.clk(clk), .reset_n(reset_n), .awvalid(awvalid),
   .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
   .bresp(bresp), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
   .rready(rready), .rdata(rdata), .rresp(rresp));
`default_nettype wire

// ### tb/cpu_call_clear_complement_ops_bench.sv
// Self-checking bench that issues instructions to cce_core over its register bus.
// Assumes the register map header; one 50 MHz clock, no other parties.
`timescale 1ns/1ps
`default_nettype none
`include "cce_map.vh"
module cpu_call_clear_complement_ops_bench;
   logic clk = 0;
   logic reset_n = 0;
   logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, v;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   int err_total = 0, checks_done = 0;
   // Free-running clock.
   always #10 clk = ~clk;
   cce_core uut (.clk(clk), .reset_n(reset_n), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
   task automatic chk(input string nm, input logic [31:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // A handshake that never completes ends the run rather than hanging it.
   task automatic tmo();
      err_total++;
      $display("mismatch handshake expected done seen timeout");
      print_verdict();
   endtask
   task automatic wr(input logic [31:0] a, d, input logic [1:0] er);
      int n;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
         if (bvalid) break;
      end
      if (n == 50) tmo();
      chk("bresp", {30'h0, bresp}, {30'h0, er});
      bready <= 1'h0;
   endtask
   task automatic rd(input logic [31:0] a, output logic [31:0] d, input logic [1:0] er);
      int n;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (arready) arvalid <= 1'h0;
         if (rvalid) break;
      end
      if (n == 50) tmo();
      d = rdata;
      chk("rresp", {30'h0, rresp}, {30'h0, er});
      rready <= 1'h0;
   endtask
   task automatic see(input string nm, input logic [31:0] a, exp);
      logic [31:0] d;
      rd(a, d, 2'h0);
      chk(nm, d, exp);
   endtask
   // Issues one instruction and waits for the busy bit to drop.
   task automatic ex(input logic [3:0] op, input logic [6:0] fa, input logic d);
      int n;
      wr(`CCE_OFF_CMD, {15'h0, d, 1'h0, fa, 4'h0, op}, 2'h0);
      for (n = 0; n < 20; n++) begin
         rd(`CCE_OFF_STATUS, v, 2'h0);
         if (v[`CCE_ST_BUSY_BIT] === 1'h0) break;
      end
      if (n == 20) tmo();
   endtask
   task automatic reset_values();
      see("status", `CCE_OFF_STATUS, 32'h6);
      see("pc", `CCE_OFF_PC, 32'h0);
   endtask
   task automatic bus_errors();
      wr(32'h40, 32'h1, 2'h2);
      rd(32'h40, v, 2'h2);
      chk("unmapped", v, 32'h0);
      wr(`CCE_OFF_STACK, 32'h77, 2'h0);
      see("stack", `CCE_OFF_STACK, 32'h0);
   endtask
   // Zero flag is set first so the call can be seen to leave it alone.
   task automatic call_test();
      ex(`CCE_OP_ACC_CLEAR, 7'h0, 1'h0);
      see("acc", `CCE_OFF_ACC, 32'h0);
      wr(`CCE_OFF_ACC, 32'h34, 2'h0);
      wr(`CCE_OFF_LATCH, 32'h5a, 2'h0);
      wr(`CCE_OFF_PC, 32'h123, 2'h0);
      ex(`CCE_OP_ACC_CALL, 7'h0, 1'h0);
      see("pc", `CCE_OFF_PC, 32'h5a34);
      see("stack", `CCE_OFF_STACK, 32'h124);
      see("status", `CCE_OFF_STATUS, 32'h10007);
   endtask
   task automatic ops_test();
      wr(`CCE_OFF_FADDR, 32'h7f, 2'h0);
      wr(`CCE_OFF_FDATA, 32'ha5, 2'h0);
      ex(`CCE_OP_FILE_INVERT, 7'h7f, 1'h1);
      see("fdata", `CCE_OFF_FDATA, 32'h5a);
      see("status", `CCE_OFF_STATUS, 32'h10006);
      ex(`CCE_OP_FILE_CLEAR, 7'h7f, 1'h0);
      see("fdata", `CCE_OFF_FDATA, 32'h0);
      see("status", `CCE_OFF_STATUS, 32'h10007);
      ex(`CCE_OP_FILE_INVERT, 7'h7f, 1'h0);
      see("acc", `CCE_OFF_ACC, 32'hff);
      see("fdata", `CCE_OFF_FDATA, 32'h0);
      wr(`CCE_OFF_FDATA, 32'h1, 2'h0);
      ex(`CCE_OP_FILE_DEC, 7'h7f, 1'h1);
      see("fdata", `CCE_OFF_FDATA, 32'h0);
      see("status", `CCE_OFF_STATUS, 32'h10007);
      ex(`CCE_OP_FILE_DEC, 7'h7f, 1'h0);
      see("acc", `CCE_OFF_ACC, 32'hff);
      see("status", `CCE_OFF_STATUS, 32'h10006);
      ex(`CCE_OP_ACC_CLEAR, 7'h0, 1'h0);
      see("acc", `CCE_OFF_ACC, 32'h0);
      see("pc", `CCE_OFF_PC, 32'h5a3a);
   endtask
   // The watchdog is left to run past its full wrap, so the timeout has cleared the
   // expiry flag and the restart has something visible to undo.
   task automatic watchdog_test();
      repeat (65600) @(posedge clk);
      see("status", `CCE_OFF_STATUS, 32'h10003);
      ex(`CCE_OP_DOG_RESTART, 7'h0, 1'h0);
      rd(`CCE_OFF_DOG, v, 2'h0);
      chk("watchdog count", {24'h0, v[7:0]}, 32'h0);
      chk("watchdog prescaler low", {31'h0, v[15:8] < 8'h40}, 32'h1);
      see("status", `CCE_OFF_STATUS, 32'h10007);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      reset_n <= 1'h1;
      reset_values();
      bus_errors();
      call_test();
      ops_test();
      watchdog_test();
      print_verdict();
   end
endmodule
`default_nettype wire
